// ---- brto_pkg.sv ----
// Purpose: shared constants and types for the boundary run-test block
// Assumes: 40-cell boundary chain, 11-bit control register, AXI4-Lite
// Notes: feedback taps and register offsets are local choices
package brto_pkg;

    // --------------------
    // boundary cell chain layout
    // --------------------
    localparam int CHAIN_W = 40;
    localparam int CELL_W = 8;
    localparam int A_IN_LSB = 0;
    localparam int A_OUT_LSB = 8;
    localparam int B_IN_LSB = 16;
    localparam int B_OUT_LSB = 24;
    localparam int CTRL_CELL_LSB = 32;
    localparam int OEA_BIT = 39;
    localparam int OEB_BIT = 38;
    localparam logic [CHAIN_W-1:0] CHAIN_RESET = 40'h00_0000_0000;

    // --------------------
    // test_operation_control_reg layout
    // --------------------
    localparam int CR_W = 11;
    localparam int CR_OP_MSB = 2;
    localparam int CR_MASK_LSB = 3;
    localparam int CR_MASK_MSB = 10;
    localparam logic [CR_W-1:0] CR_RESET = 11'h000;

    // --------------------
    // operations
    // --------------------
    typedef enum logic [2:0] {
        BRTO_OP_TOGGLE = 3'h0,
        BRTO_OP_PRPG16 = 3'h1,
        BRTO_OP_PSA16 = 3'h3,
        BRTO_OP_SIGNATURE_PLUS_PATTERN_OP = 3'h2,
        BRTO_OP_SIGNATURE_PLUS_COUNT_OP = 3'h6
    } brto_op_t;

    localparam logic [1:0] OPC_TOGGLE = 2'h0;
    localparam logic [1:0] OPC_PRPG16 = 2'h1;
    localparam logic [1:0] OPC_PSA16 = 2'h2;
    localparam logic [1:0] OPC_MIXED = 2'h3;

    // feedback taps, fibonacci form, msb shifts out
    localparam logic [15:0] TAPS16 = 16'hb400;
    localparam logic [7:0] TAPS8 = 8'hb8;

    // --------------------
    // register map (byte addresses)
    // --------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CHAIN_LO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CHAIN_HI = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_VALID_BIT = 1;
    localparam int ST_ATOB_BIT = 2;
    localparam int ST_OP_LSB = 8;

    // --------------------
    // synchronised inputs
    // --------------------
    localparam int SYNC_W = 2 * CELL_W + 3;

endpackage : brto_pkg

// ---- brto_sync.sv ----
// Purpose: two-flop synchroniser for link and pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: only the second stage may be read
`timescale 1ns/1ns
module brto_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : brto_sync

// ---- brto_core.sv ----
// Purpose: boundary run-test operations with AXI4-Lite register access
// Assumes: tck and pins are sampled by sys_clk, tck well below sys_clk/4
// Notes: chain and control register are loaded by software over AXI
//
// Overview of operation
// - opcode 011 runs 8-bit signature plus pattern
// - bits 2..0 decode toggle, pattern, signature
// - run only in run instruction and idle
// - control cells 39..32 never join algorithms
// - cells 39, 38 gate output drivers
// - only one direction enabled, else bypass
// - control bits 10..3 mask input bits 7..0
// - mask one ignores input, zero includes it
// - toggle mode samples inputs, feeds core shadows
// - toggle mode inverts output cells, falls to pins
// - 16-bit pattern steps, drives pins and core
// - all-zero seed keeps pattern generators at zero
// - 16-bit signature compresses inputs, updates core
// - 16-bit signature holds output shadows
// - combined mode: 8-bit signature and pattern
// - count mode: 16-bit count, 8-bit signature
// - sample on tck rise, outputs on fall
`timescale 1ns/1ns
module brto_core
    import brto_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // test link, from the test port controller
    input wire logic tck,
    input wire logic boundary_run_instruction,
    input wire logic tap_in_run_idle,
    // functional pins
    input wire logic [CELL_W-1:0] a_pin_i,
    output logic [CELL_W-1:0] a_pin_o,
    output logic a_pin_oe,
    input wire logic [CELL_W-1:0] b_pin_i,
    output logic [CELL_W-1:0] b_pin_o,
    output logic b_pin_oe,
    // input shadows toward core logic
    output logic [CELL_W-1:0] core_a_o,
    output logic [CELL_W-1:0] core_b_o,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // --------------------
    // step functions
    // --------------------
    // xor feedback: an all-zero state maps to zero
    function automatic logic [15:0] lfsr16(input logic [15:0] v);
        lfsr16 = {v[14:0], ^(v & TAPS16)};
    endfunction : lfsr16
    function automatic logic [7:0] lfsr8(input logic [7:0] v);
        lfsr8 = {v[6:0], ^(v & TAPS8)};
    endfunction : lfsr8
    function automatic brto_op_t op_decode(input logic [2:0] opc);
        case (opc[1:0])
            OPC_TOGGLE: op_decode = BRTO_OP_TOGGLE;
            OPC_PRPG16: op_decode = BRTO_OP_PRPG16;
            OPC_PSA16: op_decode = BRTO_OP_PSA16;
            OPC_MIXED: op_decode = opc[2] ? BRTO_OP_SIGNATURE_PLUS_COUNT_OP
                                          : BRTO_OP_SIGNATURE_PLUS_PATTERN_OP;
            default: op_decode = BRTO_OP_TOGGLE;
        endcase
    endfunction : op_decode
    // --------------------
    // input synchronisation and tck edges
    // --------------------
    logic [SYNC_W-1:0] sync_s;
    logic tck_d_q;
    brto_sync #(.W(SYNC_W)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_i({tck, boundary_run_instruction, tap_in_run_idle,
                  a_pin_i, b_pin_i}),
        .sync_o(sync_s)
    );
    wire tck_s = sync_s[SYNC_W-1];
    wire run_instr_s = sync_s[SYNC_W-2];
    wire run_idle_s = sync_s[SYNC_W-3];
    wire [CELL_W-1:0] a_pin_s = sync_s[2*CELL_W-1 -: CELL_W];
    wire [CELL_W-1:0] b_pin_s = sync_s[CELL_W-1:0];
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tck_d_q <= 1'b0;
        end else begin
            tck_d_q <= tck_s;
        end
    end
    wire tck_rise = tck_s & ~tck_d_q;
    wire tck_fall = ~tck_s & tck_d_q;
    // --------------------
    // operation select and direction
    // --------------------
    logic [CHAIN_W-1:0] chain_q, chain_d;
    logic [CR_W-1:0] ctrl_q;
    wire a_side_output_enable = chain_q[OEA_BIT];
    wire b_side_output_enable = chain_q[OEB_BIT];
    wire dir_valid = a_side_output_enable ^ b_side_output_enable;
    wire a_to_b = b_side_output_enable; // b drives: data flows a to b
    wire run_active = run_instr_s & run_idle_s & dir_valid;
    wire brto_op_t op = op_decode(ctrl_q[CR_OP_MSB:0]);
    wire [CELL_W-1:0] mask = ctrl_q[CR_MASK_MSB:CR_MASK_LSB];
    // only the four data cell groups are touched below
    wire [CELL_W-1:0] src_in = a_to_b ? chain_q[A_IN_LSB +: CELL_W]
                                      : chain_q[B_IN_LSB +: CELL_W];
    wire [CELL_W-1:0] dst_out = a_to_b ? chain_q[B_OUT_LSB +: CELL_W]
                                       : chain_q[A_OUT_LSB +: CELL_W];
    wire [CELL_W-1:0] opp_out = a_to_b ? chain_q[A_OUT_LSB +: CELL_W]
                                       : chain_q[B_OUT_LSB +: CELL_W];
    wire [CELL_W-1:0] src_pins = a_to_b ? a_pin_s : b_pin_s;
    wire [CELL_W-1:0] masked = src_pins & ~mask;
    // --------------------
    // next chain contents on a tck rise
    // --------------------
    logic [CELL_W-1:0] src_n, dst_n, opp_n;
    logic carry;
    always_comb begin
        src_n = src_in;
        dst_n = dst_out;
        opp_n = opp_out;
        carry = 1'b0;
        case (op)
            BRTO_OP_TOGGLE: begin
                src_n = src_pins;
                dst_n = ~dst_out;
            end
            BRTO_OP_PRPG16: begin
                {dst_n, src_n} = lfsr16({dst_out, src_in});
            end
            BRTO_OP_PSA16: begin
                {dst_n, src_n} = lfsr16({dst_out, src_in})
                               ^ {{CELL_W{1'b0}}, masked};
            end
            BRTO_OP_SIGNATURE_PLUS_PATTERN_OP: begin
                src_n = lfsr8(src_in) ^ masked;
                dst_n = lfsr8(dst_out);
            end
            BRTO_OP_SIGNATURE_PLUS_COUNT_OP: begin
                src_n = lfsr8(src_in) ^ masked;
                {carry, dst_n} = {1'b0, dst_out} + 9'h001;
                opp_n = opp_out + {{(CELL_W-1){1'b0}}, carry};
            end
            default: begin
                src_n = src_in;
            end
        endcase
    end
    // control cells 39..32 and the idle cells pass straight through
    always_comb begin
        chain_d = chain_q;
        if (a_to_b) begin
            chain_d[A_IN_LSB +: CELL_W] = src_n;
            chain_d[B_OUT_LSB +: CELL_W] = dst_n;
            chain_d[A_OUT_LSB +: CELL_W] = opp_n;
        end else begin
            chain_d[B_IN_LSB +: CELL_W] = src_n;
            chain_d[A_OUT_LSB +: CELL_W] = dst_n;
            chain_d[B_OUT_LSB +: CELL_W] = opp_n;
        end
    end
    // --------------------
    // axi4-lite slave
    // --------------------
    logic aw_held_q, w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire b_done = s_axi_bvalid & s_axi_bready;
    wire r_done = s_axi_rvalid & s_axi_rready;
    wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire wr_ctrl = wr_go & (awaddr_q == OFS_CTRL);
    wire wr_lo = wr_go & (awaddr_q == OFS_CHAIN_LO);
    wire wr_hi = wr_go & (awaddr_q == OFS_CHAIN_HI);
    wire wr_map = wr_ctrl | wr_lo | wr_hi | (awaddr_q == OFS_STATUS);
    wire [31:0] status_w = {21'h000000, op, 5'h00, a_to_b, dir_valid,
                            run_active};
    wire [31:0] rd_mux =
        (s_axi_araddr == OFS_CTRL) ? {21'h000000, ctrl_q} :
        (s_axi_araddr == OFS_CHAIN_LO) ? chain_q[31:0] :
        (s_axi_araddr == OFS_CHAIN_HI) ?
            {24'h000000, chain_q[CHAIN_W-1:CTRL_CELL_LSB]} :
        (s_axi_araddr == OFS_STATUS) ? status_w : 32'h0000_0000;
    wire rd_map = (s_axi_araddr == OFS_CTRL) |
                  (s_axi_araddr == OFS_CHAIN_LO) |
                  (s_axi_araddr == OFS_CHAIN_HI) |
                  (s_axi_araddr == OFS_STATUS);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
            s_axi_awready <= ~aw_take & ~aw_held_q & ~s_axi_bvalid;
            s_axi_wready <= ~w_take & ~w_held_q & ~s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (b_done) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end else if (r_done) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // --------------------
    // control register and chain
    // --------------------
    // byte-lane merge for the chain words
    function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge
    wire [31:0] ctrl_m = merge({21'h000000, ctrl_q}, wdata_q, wstrb_q);
    wire [31:0] lo_m = merge(chain_q[31:0], wdata_q, wstrb_q);
    wire [31:0] hi_m = merge({24'h000000, chain_q[CHAIN_W-1:CTRL_CELL_LSB]},
                             wdata_q, wstrb_q);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= CR_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_m[CR_W-1:0];
        end
    end
    // software seed load wins over a concurrent step
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            chain_q <= CHAIN_RESET;
        end else if (wr_lo) begin
            chain_q[31:0] <= lo_m;
        end else if (wr_hi) begin
            chain_q[CHAIN_W-1:CTRL_CELL_LSB] <= hi_m[CELL_W-1:0];
        end else if (run_active & tck_rise) begin
            chain_q <= chain_d;
        end
    end
    // --------------------
    // shadow latches, updated on tck fall
    // --------------------
    wire shadow_upd = run_active & tck_fall;
    wire out_upd = shadow_upd & (op != BRTO_OP_PSA16);
    wire in_upd = shadow_upd;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            a_pin_o <= '0;
            b_pin_o <= '0;
            a_pin_oe <= 1'b0;
            b_pin_oe <= 1'b0;
            core_a_o <= '0;
            core_b_o <= '0;
        end else begin
            if (!run_instr_s) begin
                a_pin_oe <= 1'b0;
                b_pin_oe <= 1'b0;
            end else if (tck_fall) begin
                a_pin_oe <= a_side_output_enable & dir_valid;
                b_pin_oe <= b_side_output_enable & dir_valid;
            end
            if (out_upd & a_to_b) begin
                b_pin_o <= chain_q[B_OUT_LSB +: CELL_W];
            end else if (out_upd) begin
                a_pin_o <= chain_q[A_OUT_LSB +: CELL_W];
            end
            if (in_upd & a_to_b) begin
                core_a_o <= chain_q[A_IN_LSB +: CELL_W];
            end else if (in_upd) begin
                core_b_o <= chain_q[B_IN_LSB +: CELL_W];
            end
        end
    end

endmodule : brto_core

// ---- brto_core_props.sv ----
// Purpose: port-level assertions for brto_core
// Assumes: tck phases last far longer than the 3-cycle sync lag
// Notes: bound to every brto_core instance
`timescale 1ns/1ns
module brto_core_props
    import brto_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link
    input wire logic tck,
    input wire logic boundary_run_instruction,
    // pins and core shadows
    input wire logic [CELL_W-1:0] a_pin_o,
    input wire logic a_pin_oe,
    input wire logic [CELL_W-1:0] b_pin_o,
    input wire logic b_pin_oe,
    input wire logic [CELL_W-1:0] core_a_o,
    input wire logic [CELL_W-1:0] core_b_o,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // --------------------
    // sequences
    // --------------------
    // long enough to cover the two sync flops and the output register
    sequence s_run_off;
        !boundary_run_instruction [*5];
    endsequence
    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_pin_moved;
        $changed(a_pin_o) || $changed(b_pin_o);
    endsequence

    a_oe_run_off: assert property (s_run_off |-> !a_pin_oe && !b_pin_oe)
        else $error("drive enable high without run instruction");
    a_hold_run_off: assert property (s_run_off |-> $stable(a_pin_o) &&
        $stable(b_pin_o) && $stable(core_a_o) && $stable(core_b_o))
        else $error("pins or shadows moved without run instruction");
    a_oe_one_side: assert property (!(a_pin_oe && b_pin_oe))
        else $error("both sides driving");
    a_pin_on_fall: assert property (s_pin_moved |-> !$past(tck, 2))
        else $error("output pins changed away from a tck fall");
    a_core_on_fall: assert property (($changed(core_a_o) ||
        $changed(core_b_o)) |-> !$past(tck, 2))
        else $error("core shadows changed away from a tck fall");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_write_answer: assert property (s_aw_taken |-> ##[2:8] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("read answer missing");
endmodule : brto_core_props

bind brto_core brto_core_props u_props (
    .sys_clk(sys_clk), .resetn(resetn), .tck(tck),
    .boundary_run_instruction(boundary_run_instruction),
    .a_pin_o(a_pin_o), .a_pin_oe(a_pin_oe), .b_pin_o(b_pin_o),
    .b_pin_oe(b_pin_oe), .core_a_o(core_a_o), .core_b_o(core_b_o),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ---- brto_tap_model.sv ----
// Purpose: test port controller model driving the run-test link
// Assumes: 125 ns test clock, held low outside frames
// Notes: state lines only move while tck is low
`timescale 1ns/1ns
module brto_tap_model (
    // system clock, only to pace the state lines
    input wire logic sys_clk,
    // link toward the block
    output logic tck,
    output logic boundary_run_instruction,
    output logic tap_in_run_idle
);
    initial {tck, boundary_run_instruction, tap_in_run_idle} = 3'h0;

    // enter run-test with n test clocks; stays in the state on return
    task frame(input int n, input logic idle_v);
        @(posedge sys_clk);
        boundary_run_instruction <= 1'b1;
        tap_in_run_idle <= idle_v;
        repeat (8) @(posedge sys_clk);
        for (int k = 0; k < n; k++) begin
            #62 tck = 1'b1;
            #63 tck = 1'b0;
        end
        repeat (10) @(posedge sys_clk);
    endtask : frame

    task stop();
        @(posedge sys_clk);
        boundary_run_instruction <= 1'b0;
        tap_in_run_idle <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : stop
endmodule : brto_tap_model

// ---- boundary_run_test_operations_tb_top.sv ----
// Purpose: self-checking bench for brto_core
// Assumes: pins held constant during each frame
// Notes: expected chain worked out by a local step model
`timescale 1ns/1ns
module boundary_run_test_operations_tb_top;
    import brto_pkg::*;
    logic sys_clk, resetn, tck, run_i, idle_i;
    logic [7:0] a_pin_i, b_pin_i, a_pin_o, b_pin_o, core_a_o, core_b_o;
    logic a_pin_oe, b_pin_oe;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int fail_count = 0;
    int comparisons = 0;
    // --------------------
    // case table: control, chain hi, chain lo, tck count, idle
    // --------------------
    logic [10:0] r_cr [12] = '{11'h000, 11'h004, 11'h001, 11'h005,
        11'h782, 11'h006, 11'h07b, 11'h007, 11'h0ff, 11'h000, 11'h001,
        11'h000};
    logic [7:0] r_hi [12] = '{8'h5f, 8'h80, 8'h40, 8'h40, 8'h40, 8'h80,
        8'h80, 8'h80, 8'h40, 8'h00, 8'hc0, 8'h40};
    logic [31:0] r_lo [12] = '{32'h5a00_0000, 32'h0000_3300,
        32'h0100_0001, 32'h0, 32'h1200_0034, 32'h0077_9900,
        32'h00cd_ab00, 32'h1200_fe00, 32'hfe00_12ff, 32'h5a5a_5a5a,
        32'h0000_0101, 32'h5a00_0000};
    int r_n [12] = '{3, 2, 5, 3, 4, 3, 4, 3, 3, 2, 2, 2};
    logic r_idle [12] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0};

    brto_core uut (.sys_clk(sys_clk), .resetn(resetn), .tck(tck),
        .boundary_run_instruction(run_i), .tap_in_run_idle(idle_i),
        .a_pin_i(a_pin_i), .a_pin_o(a_pin_o), .a_pin_oe(a_pin_oe),
        .b_pin_i(b_pin_i), .b_pin_o(b_pin_o), .b_pin_oe(b_pin_oe),
        .core_a_o(core_a_o), .core_b_o(core_b_o),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    brto_tap_model tap (.sys_clk(sys_clk), .tck(tck),
        .boundary_run_instruction(run_i), .tap_in_run_idle(idle_i));

    function automatic logic [15:0] l16(input logic [15:0] s);
        return {s[14:0], ^(s & TAPS16)};
    endfunction : l16
    function automatic logic [7:0] l8(input logic [7:0] s);
        return {s[6:0], ^(s & TAPS8)};
    endfunction : l8
    // one tck rise of the selected operation
    function automatic logic [39:0] step(input logic [39:0] c,
        input logic [10:0] cr, input logic [7:0] ap, input logic [7:0] bp);
        logic atob;
        int si, di, oi;
        logic [7:0] p, m;
        logic [8:0] cnt;
        atob = c[OEB_BIT] & ~c[OEA_BIT];
        si = atob ? A_IN_LSB : B_IN_LSB;
        di = atob ? B_OUT_LSB : A_OUT_LSB;
        oi = atob ? A_OUT_LSB : B_OUT_LSB;
        p = atob ? ap : bp;
        m = p & ~cr[CR_MASK_MSB:CR_MASK_LSB];
        cnt = {1'b0, c[di+:8]} + 9'h001;
        if (c[OEA_BIT] == c[OEB_BIT]) return c;
        if (cr[1:0] == 2'b11) c[si+:8] = l8(c[si+:8]) ^ m;
        if (cr[2:0] == 3'b011) c[di+:8] = l8(c[di+:8]);
        if (cr[2:0] == 3'b111) begin
            c[di+:8] = cnt[7:0];
            c[oi+:8] = c[oi+:8] + {7'h00, cnt[8]};
        end
        if (cr[1:0] == 2'b00) {c[di+:8], c[si+:8]} = {~c[di+:8], p};
        if (cr[1:0] == 2'b01) {c[di+:8], c[si+:8]} = l16({c[di+:8], c[si+:8]});
        if (cr[1:0] == 2'b10) {c[di+:8], c[si+:8]} =
            l16({c[di+:8], c[si+:8]}) ^ {8'h00, m};
        return c;
    endfunction : step

    task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task axi_wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task end_sim();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // whole run is near 1200 cycles; cut off well beyond
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end

    initial begin
        logic [39:0] ex, snap;
        logic [31:0] rd;
        logic [1:0] rr;
        logic atob;
        int si, di;
        resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        a_pin_i = 8'h3c;
        b_pin_i = 8'hc5;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        foreach (r_n[i]) begin
            axi_rd(OFS_CTRL + 8'(4 * (i % 3)), rd, rr);
            chk("reset_reg", 32'h0, rd);
            if (i > 2) break;
        end
        axi_rd(8'h10, rd, rr);
        chk("unmapped_rresp", RESP_SLVERR, rr);
        axi_wr(8'h10, 32'hffff_ffff, RESP_SLVERR);
        axi_wr(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
        $display("test registers done");
        foreach (r_n[i]) begin
            axi_wr(OFS_CHAIN_LO, r_lo[i], RESP_OKAY);
            axi_wr(OFS_CHAIN_HI, {24'h0, r_hi[i]}, RESP_OKAY);
            axi_wr(OFS_CTRL, {21'h0, r_cr[i]}, RESP_OKAY);
            ex = {r_hi[i], r_lo[i]};
            for (int k = 0; k < r_n[i] && r_idle[i]; k++)
                ex = step(ex, r_cr[i], a_pin_i, b_pin_i);
            atob = ex[OEB_BIT] & ~ex[OEA_BIT];
            si = atob ? A_IN_LSB : B_IN_LSB;
            di = atob ? B_OUT_LSB : A_OUT_LSB;
            snap = {8'h00, a_pin_o, b_pin_o, core_a_o, core_b_o};
            tap.frame(r_n[i], r_idle[i]);
            axi_rd(OFS_CHAIN_LO, rd, rr);
            chk("chain_lo", ex[31:0], rd);
            axi_rd(OFS_CHAIN_HI, rd, rr);
            chk("chain_hi", ex[39:32], rd[7:0]);
            if (ex[OEA_BIT] != ex[OEB_BIT] && r_idle[i]) begin
                chk("dst_pin", r_cr[i][1:0] == 2'b10 ?
                    (atob ? snap[15:8] : snap[31:24]) : ex[di+:8],
                    atob ? b_pin_o : a_pin_o);
                chk("src_core", ex[si+:8],
                    atob ? core_a_o : core_b_o);
                chk("oe", {atob, ~atob}, {b_pin_oe, a_pin_oe});
            end else begin
                chk("held", snap,
                    {8'h00, a_pin_o, b_pin_o, core_a_o, core_b_o});
            end
            tap.stop();
            $display("test case %0d done", i);
        end
        end_sim();
    end
endmodule : boundary_run_test_operations_tb_top
